// ### hw/cabr_pkg.sv
// package for the address buffer host-side controller
// assumes one 200 MHz clock; the device pins are sampled synchronously
package cabr_pkg;
   localparam int CPU_AW       = 16;
   localparam int DRAM_AW      = 8;
   localparam int REFCNT_W     = 9;
   localparam int SYS_AW       = 17;
   localparam logic [REFCNT_W-1:0] REFCNT_RST = 9'h000;
   localparam real CLK_PERIOD_NS = 5.0;
   // least time the refresh strobe stays low, as chosen for this controller
   localparam real REF_LOW_NS  = 20.0;
   localparam int  REF_LOW_CYC =
      (int'($ceil(REF_LOW_NS / CLK_PERIOD_NS)) < 1) ? 1 :
      int'($ceil(REF_LOW_NS / CLK_PERIOD_NS));
   localparam logic [7:0] REF_LOW_CNT = 8'(REF_LOW_CYC);

   typedef enum logic [1:0] {
      CABR_OWN_CPU,
      CABR_OWN_DMA,
      CABR_OWN_REFRESH,
      CABR_OWN_MASTER
   } cabr_owner_t;

   // pins the controller drives towards the device
   typedef struct packed {
      logic [CPU_AW-1:0] cpu_addr;
      logic              ale;
      logic              early_ram_latch_strobe;
      logic              cpu_byte_high_en_n;
      logic              hold_ack;
      logic              dma_addr_en_n;
      logic              refresh_strobe_n;
      logic              refresh_en_n;
      logic              row_col_select;
      logic              sys_reset;
   } cabr_ctl_t;

   // user-side cycle request
   typedef struct packed {
      logic              valid;
      cabr_owner_t       owner;
      logic [CPU_AW-1:0] addr;
      logic              upper_byte;
      logic              fast_memory_mode;
      logic              mem_cycle;
   } cabr_req_t;
endpackage

// ### hw/cabr_strobe_gen.sv
// pulse generator for one active strobe of fixed length
// assumes the caller starts it only when idle
`timescale 1ns/1ps
module cabr_strobe_gen
   import cabr_pkg::*;
#(
   parameter logic [7:0] LEN = 8'h04
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic start,
   output logic      active,
   output logic      done
);
   logic [7:0] count;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= 8'h00;
      end else if (clk_en) begin
         if (start && count == 8'h00) begin
            count <= LEN;
         end else if (count != 8'h00) begin
            count <= count - 8'h01;
         end
      end
   end

   assign active = (count != 8'h00);
   assign done   = clk_en && (count == 8'h01);
endmodule

// ### hw/cabr_host.sv
// host-side controller driving the address buffer's control pins
// assumes the device pins are sampled on mclk and the device is clockless
`timescale 1ns/1ps
// Functional notes
// - no address latch strobe pulse in a halt cycle
// - fast mode raises early strobe with memory strobe, else equals ale
// - hold acknowledge high only after cpu drivers three-stated
// - cpu byte-high-enable low whenever upper data byte is used
// - dma address enable held low for the entire dma access
// - refresh enable low whenever a dram refresh is required
module cabr_host
   import cabr_pkg::*;
#(
   parameter int REF_CNT_W = REFCNT_W
) (
   input  wire logic                mclk,
   input  wire logic                sys_rst,
   input  wire logic                clk_en,
   input  wire cabr_req_t           req,
   output logic                     req_ready,
   output logic                     busy,
   output cabr_ctl_t                ctl,
   output logic                     cpu_addr_oe,
   output logic                     mem_read_strobe_n,
   output logic                     mem_write_strobe_n,
   output logic [REF_CNT_W-1:0]     refresh_count_model,
   input  wire logic                refresh_counter_msb,
   output logic                     msb_mismatch
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HOLD_WAIT,
      ST_ADDR,
      ST_LATCH,
      ST_ROW,
      ST_COL,
      ST_REF_STROBE,
      ST_RELEASE
   } cabr_state_t;

   cabr_state_t state;
   cabr_req_t   cur;
   logic        pulse_start;
   logic        pulse_active;
   logic        pulse_done;

   cabr_strobe_gen #(.LEN(REF_LOW_CNT)) u_pulse (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .start   (pulse_start),
      .active  (pulse_active),
      .done    (pulse_done)
   );

   assign req_ready   = (state == ST_IDLE) && !sys_rst;
   assign busy        = (state != ST_IDLE);
   assign pulse_start = clk_en && (state == ST_REF_STROBE) && !pulse_active;

   // sequencing of one cycle per request
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         cur   <= '0;
      end else if (clk_en) begin
         case (state)
            ST_IDLE: begin
               if (req.valid) begin
                  cur   <= req;
                  state <= (req.owner == CABR_OWN_CPU) ? ST_ADDR
                                                        : ST_HOLD_WAIT;
               end
            end
            ST_HOLD_WAIT: state <= ST_ADDR;
            ST_ADDR: begin
               if (cur.owner == CABR_OWN_REFRESH) begin
                  state <= ST_REF_STROBE;
               end else begin
                  state <= ST_LATCH;
               end
            end
            ST_LATCH: state <= cur.mem_cycle ? ST_ROW : ST_RELEASE;
            ST_ROW:   state <= ST_COL;
            ST_COL:   state <= ST_RELEASE;
            ST_REF_STROBE: begin
               if (pulse_done) begin
                  state <= ST_RELEASE;
               end
            end
            ST_RELEASE: state <= ST_IDLE;
            default:  state <= ST_IDLE;
         endcase
      end
   end

   // pin drive; every pin is a flip-flop so the device sees clean levels
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl                <= '0;
         ctl.cpu_byte_high_en_n <= 1'b1;
         ctl.dma_addr_en_n  <= 1'b1;
         ctl.refresh_strobe_n <= 1'b1;
         ctl.refresh_en_n   <= 1'b1;
         ctl.sys_reset      <= 1'b1;
         cpu_addr_oe        <= 1'b0;
      end else if (clk_en) begin
         ctl.sys_reset <= 1'b0;
         case (state)
            ST_IDLE: begin
               ctl.ale                    <= 1'b0;
               ctl.early_ram_latch_strobe <= 1'b0;
               ctl.row_col_select         <= 1'b0;
               if (req.valid) begin
                  // cpu drivers go off before hold is reported
                  cpu_addr_oe <= (req.owner == CABR_OWN_CPU);
                  ctl.cpu_addr <= req.addr;
                  ctl.cpu_byte_high_en_n <= !req.upper_byte;
               end
            end
            ST_HOLD_WAIT: begin
               ctl.hold_ack <= 1'b1;
               ctl.dma_addr_en_n <=
                  !(cur.owner == CABR_OWN_DMA);
               ctl.refresh_en_n <=
                  !(cur.owner == CABR_OWN_REFRESH);
            end
            ST_ADDR: begin
               // a halt cycle (cpu, no memory, address zero) gets no ale
               if (!(cur.owner == CABR_OWN_CPU && !cur.mem_cycle &&
                     cur.addr == '0)) begin
                  ctl.ale <= (cur.owner != CABR_OWN_REFRESH);
               end
               if (cur.mem_cycle && cur.fast_memory_mode) begin
                  ctl.early_ram_latch_strobe <= 1'b1;
               end else begin
                  ctl.early_ram_latch_strobe <=
                     (cur.owner != CABR_OWN_REFRESH) &&
                     !(cur.owner == CABR_OWN_CPU && !cur.mem_cycle &&
                       cur.addr == '0);
               end
            end
            ST_LATCH: begin
               ctl.ale                    <= 1'b0;
               ctl.early_ram_latch_strobe <= 1'b0;
            end
            ST_ROW: ctl.row_col_select <= 1'b0;
            ST_COL: ctl.row_col_select <= 1'b1;
            ST_REF_STROBE: begin
               ctl.refresh_strobe_n <= !pulse_active;
            end
            ST_RELEASE: begin
               ctl.refresh_strobe_n   <= 1'b1;
               ctl.refresh_en_n       <= 1'b1;
               ctl.dma_addr_en_n      <= 1'b1;
               ctl.hold_ack           <= 1'b0;
               ctl.row_col_select     <= 1'b0;
               ctl.cpu_byte_high_en_n <= 1'b1;
               cpu_addr_oe            <= 1'b0;
            end
            default: ctl.ale <= 1'b0;
         endcase
      end
   end

   // memory strobes; upper_byte picks write so one field serves both
   // fast mode opens them in the address state, next to the early strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_read_strobe_n  <= 1'b1;
         mem_write_strobe_n <= 1'b1;
      end else if (clk_en) begin
         case (state)
            ST_ADDR: begin
               if (cur.mem_cycle && cur.fast_memory_mode) begin
                  mem_read_strobe_n  <= cur.upper_byte;
                  mem_write_strobe_n <= !cur.upper_byte;
               end
            end
            ST_LATCH: begin
               if (cur.mem_cycle) begin
                  mem_read_strobe_n  <= cur.upper_byte;
                  mem_write_strobe_n <= !cur.upper_byte;
               end
            end
            ST_IDLE, ST_RELEASE: begin
               mem_read_strobe_n  <= 1'b1;
               mem_write_strobe_n <= 1'b1;
            end
            default: begin
               mem_read_strobe_n  <= mem_read_strobe_n;
               mem_write_strobe_n <= mem_write_strobe_n;
            end
         endcase
      end
   end

   // shadow of the device counter, stepped on each strobe release
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         refresh_count_model <= REF_CNT_W'(REFCNT_RST);
         msb_mismatch        <= 1'b0;
      end else if (clk_en) begin
         if (state == ST_RELEASE && cur.owner == CABR_OWN_REFRESH) begin
            // plain increment wraps all ones to zero
            refresh_count_model <= refresh_count_model +
                                   REF_CNT_W'(1);
         end
         msb_mismatch <= (state == ST_IDLE) &&
            (refresh_counter_msb !=
             refresh_count_model[REF_CNT_W-1]);
      end
   end
endmodule

// ### bench/cabr_host_properties.sv
// checker for the host controller's control pin sequencing
// assumes it is bound onto cabr_host and sees only its ports
`timescale 1ns/1ps
module cabr_host_properties
   import cabr_pkg::*;
#(
   parameter int REF_CNT_W = REFCNT_W
) (
   input wire logic                 mclk,
   input wire logic                 sys_rst,
   input wire logic                 clk_en,
   input wire cabr_req_t            req,
   input wire logic                 req_ready,
   input wire logic                 busy,
   input wire cabr_ctl_t            ctl,
   input wire logic                 cpu_addr_oe,
   input wire logic                 mem_read_strobe_n,
   input wire logic                 mem_write_strobe_n,
   input wire logic [REF_CNT_W-1:0] refresh_count_model,
   input wire logic                 refresh_counter_msb,
   input wire logic                 msb_mismatch
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic take;
   logic mem_on;
   assign take = clk_en && req.valid && req_ready;
   assign mem_on = !(mem_read_strobe_n && mem_write_strobe_n);
   chk_hold_no_cpu:
   assert property (ctl.hold_ack |-> !cpu_addr_oe)
      else $error("hold acknowledge while cpu drives address");
   chk_halt_no_ale:
   assert property (take && req.owner == CABR_OWN_CPU && !req.mem_cycle &&
      req.addr == '0 |=> !ctl.ale [*6])
      else $error("address strobe pulsed in halt cycle");
   chk_slow_early_eq:
   assert property (take && !req.fast_memory_mode |=>
      (ctl.early_ram_latch_strobe == ctl.ale) [*6])
      else $error("early strobe differs from address strobe");
   chk_fast_early_mem:
   assert property (take && req.fast_memory_mode && req.mem_cycle |->
      ##[1:4] (ctl.early_ram_latch_strobe && mem_on))
      else $error("early strobe not raised with memory strobe");
   chk_upper_byte_en:
   assert property (take && req.upper_byte && req.owner == CABR_OWN_CPU |->
      ##[1:2] !ctl.cpu_byte_high_en_n)
      else $error("byte high enable not low for upper byte");
   chk_dma_en_low:
   assert property (take && req.owner == CABR_OWN_DMA |->
      ##[1:3] !ctl.dma_addr_en_n)
      else $error("dma address enable not lowered");
   chk_dma_under_hold:
   assert property (!ctl.dma_addr_en_n |-> ctl.hold_ack)
      else $error("dma address enable low without hold");
   chk_refresh_en_low:
   assert property (!ctl.refresh_strobe_n |-> !ctl.refresh_en_n)
      else $error("refresh strobe low without refresh enable");
   chk_refresh_len:
   assert property ($fell(ctl.refresh_strobe_n) |-> !ctl.refresh_strobe_n [*4])
      else $error("refresh strobe low time too short");
   cover property (take && req.owner == CABR_OWN_REFRESH);
   cover property (take && req.owner == CABR_OWN_DMA);
   cover property (take && req.fast_memory_mode && req.mem_cycle);
endmodule
bind cabr_host cabr_host_properties #(.REF_CNT_W(REF_CNT_W)) i_chk (
   .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
   .req_ready(req_ready), .busy(busy), .ctl(ctl), .cpu_addr_oe(cpu_addr_oe),
   .mem_read_strobe_n(mem_read_strobe_n),
   .mem_write_strobe_n(mem_write_strobe_n),
   .refresh_count_model(refresh_count_model),
   .refresh_counter_msb(refresh_counter_msb), .msb_mismatch(msb_mismatch));

// ### bench/cabr_device_model.sv
// behavioural model of the address buffer device
// assumes it is driven by the controller's registered control pins
`timescale 1ns/1ps
module cabr_device_model
   import cabr_pkg::*;
(
   input  wire cabr_ctl_t         ctl,
   output logic                   refresh_counter_msb,
   output logic [DRAM_AW-1:0]     dram_addr,
   output logic                   sys_addr0_oe,
   output logic                   sys_byte_high_en_oe
);
   logic [REFCNT_W-1:0] count;
   logic [REFCNT_W-1:0] held;
   logic [CPU_AW-1:0]   sa_latch;
   logic [CPU_AW-1:0]   ma_latch;
   wire logic ref_n = ctl.refresh_strobe_n;
   wire logic rst = ctl.sys_reset;
   wire logic ren_n = ctl.refresh_en_n;
   // no saturation: the count simply rolls over
   always @(posedge ref_n or posedge rst) begin
      if (rst) count <= '0;
      else count <= count + 1'b1;
   end
   always @(negedge ren_n) held <= count;
   always_latch if (ctl.ale) sa_latch <= ctl.cpu_addr;
   always_latch if (ctl.early_ram_latch_strobe) ma_latch <= ctl.cpu_addr;
   assign refresh_counter_msb = count[REFCNT_W-1];
   assign sys_addr0_oe = ctl.hold_ack && !ren_n;
   assign sys_byte_high_en_oe = !ctl.hold_ack;
   always_comb begin
      if (ctl.hold_ack && !ren_n)
         dram_addr = ctl.row_col_select ? 8'h00 : {held[0], held[7:1]};
      else if (ctl.hold_ack)
         dram_addr = ctl.row_col_select ? sa_latch[15:8] : sa_latch[7:0];
      else
         dram_addr = ctl.row_col_select ? ma_latch[15:8] : ma_latch[7:0];
   end
endmodule

// ### bench/cabr_host_tb.sv
// self-checking bench for the address buffer host controller
// assumes the device model answers the refresh counter pin
`timescale 1ns/1ps
module cabr_host_tb;
   import cabr_pkg::*;
   logic                mclk = 0, sys_rst = 1, clk_en = 1;
   cabr_req_t           req = '0;
   cabr_ctl_t           ctl;
   logic                req_ready, busy, oe, rd_n, wr_n, msb, mism, sa0_oe;
   logic [REFCNT_W-1:0] cnt;
   logic [DRAM_AW-1:0]  ma;
   logic                s_ale = 0, s_rd = 0, s_wr = 0, s_dma = 0, s_sa0 = 0;
   logic                s_clr = 0;
   logic [DRAM_AW-1:0]  s_col = '0;
   int                  mismatches = 0, n_checks = 0;
   initial forever #2.5 mclk = ~mclk;
   cabr_host i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .req(req), .req_ready(req_ready), .busy(busy), .ctl(ctl),
      .cpu_addr_oe(oe), .mem_read_strobe_n(rd_n), .mem_write_strobe_n(wr_n),
      .refresh_count_model(cnt), .refresh_counter_msb(msb),
      .msb_mismatch(mism));
   cabr_device_model i_dev (.ctl(ctl), .refresh_counter_msb(msb),
      .dram_addr(ma), .sys_addr0_oe(sa0_oe), .sys_byte_high_en_oe());
   // sticky flags, cleared at the edge that takes a request
   always @(posedge mclk) begin
      if (s_clr) begin
         {s_ale, s_rd, s_wr, s_dma, s_sa0} <= '0;
         s_col <= '0;
      end else begin
         s_ale <= s_ale | ctl.ale;
         s_rd <= s_rd | !rd_n;
         s_wr <= s_wr | !wr_n;
         s_dma <= s_dma | !ctl.dma_addr_en_n;
         s_sa0 <= s_sa0 | sa0_oe;
         if (ctl.row_col_select) s_col <= ma;
      end
   end
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // a hang counts as a mismatch and ends the run
   task automatic hang;
      mismatches++;
      report_and_stop();
   endtask
   task automatic run(cabr_owner_t o, logic [15:0] a, logic up, f, m);
      int i;
      @(negedge mclk);
      s_clr = 1'b1;
      req = '{1'b1, o, a, up, f, m};
      for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge mclk);
      if (req_ready !== 1'b1) hang();
      @(negedge mclk);
      s_clr = 1'b0;
      req.valid = 1'b0;
      for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge mclk);
      if (busy !== 1'b0) hang();
   endtask
   task automatic t_mem_read;
      run(CABR_OWN_CPU, 16'ha5c3, 0, 0, 1);
      check("read strobe", s_rd, 1);
      check("dram addr", ma, 16'h00c3);
      check("dram column", s_col, 16'h00a5);
   endtask
   task automatic t_fast_write;
      run(CABR_OWN_CPU, 16'h3c5a, 1, 1, 1);
      check("write strobe", s_wr, 1);
      check("fast dram addr", ma, 16'h005a);
      check("fast dram column", s_col, 16'h003c);
   endtask
   task automatic t_halt;
      run(CABR_OWN_CPU, 16'h0000, 0, 0, 0);
      check("halt strobe", s_ale, 0);
      check("halt dram addr", ma, 16'h005a);
   endtask
   task automatic t_dma;
      run(CABR_OWN_DMA, 16'h1234, 0, 0, 1);
      check("dma enable", s_dma, 1);
   endtask
   // slot master under hold: neither dma nor refresh enable may drop
   task automatic t_master;
      run(CABR_OWN_MASTER, 16'h4321, 0, 0, 1);
      check("master dma enable", s_dma, 0);
      check("master sa0", s_sa0, 0);
   endtask
   task automatic t_refresh_wrap;
      for (int k = 1; k <= 512; k++) begin
         run(CABR_OWN_REFRESH, 16'h0000, 0, 0, 0);
         if (k == 1) check("refresh sa0", s_sa0, 1);
         if (k == 256) check("msb at half", msb, 1);
      end
      check("wrapped count", 16'(cnt), 0);
      check("msb agree", mism, 0);
   endtask
   // second reset mid-run must clear the device counter again
   task automatic t_mid_reset;
      repeat (300) run(CABR_OWN_REFRESH, 16'h0000, 0, 0, 0);
      @(negedge mclk);
      sys_rst = 1;
      repeat (2) @(negedge mclk);
      sys_rst = 0;
      @(negedge mclk);
      check("msb after reset", msb, 0);
      check("count after reset", 16'(cnt), 0);
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      sys_rst = 0;
      t_mem_read();
      t_fast_write();
      t_halt();
      t_dma();
      t_master();
      t_refresh_wrap();
      t_mid_reset();
      report_and_stop();
   end
endmodule
